//--- hdl/trog_consts.svh
// Purpose: Offsets, field positions, reset values and timing counts
// Assumes: 20 MHz core clock
// Notes:   Definitions only
`ifndef TROG_CONSTS_SVH
`define TROG_CONSTS_SVH

// ****************************************
// Timing
// ****************************************
`define TROG_CLK_HZ        20000000
`define TROG_UPDATE_HZ     16000
`define TROG_TICK_CYCLES   (`TROG_CLK_HZ / `TROG_UPDATE_HZ)
`define TROG_TICK_CW       11

// ****************************************
// Direct register offsets
// ****************************************
`define TROG_DIR_DATA      5'h1C
`define TROG_DIR_ADDR      5'h1D
`define TROG_DIR_STATUS    5'h1F
`define TROG_STAT_PEND_BIT 0

// ****************************************
// Indirect locations
// ****************************************
`define TROG_IX_TONE1_FREQ 4'h0
`define TROG_IX_TONE1_AMP  4'h1
`define TROG_IX_TONE1_PH   4'h2
`define TROG_IX_TONE2_FREQ 4'h3
`define TROG_IX_TONE2_AMP  4'h4
`define TROG_IX_TONE2_PH   4'h5
`define TROG_IX_RING_OFS   4'h6
`define TROG_IX_RING_FREQ  4'h7
`define TROG_IX_RING_AMP   4'h8
`define TROG_IX_RING_PH    4'h9
`define TROG_IX_RX_GAIN    4'hD
`define TROG_IX_TX_GAIN    4'hE
`define TROG_IX_IMPL_MASK  16'h63FF

// ****************************************
// Fields and reset values
// ****************************************
`define TROG_ROF_MSB       5
`define TROG_GAIN_MSB      11
`define TROG_GAIN_FRAC     10
`define TROG_GAIN_UNITY    12'h400
`define TROG_GAIN_MAX      12'h7FF
`define TROG_WORD_RST      16'h0000

`endif

//--- hdl/trog_pkg.sv
// Purpose: Shared types of the coefficient bank
// Assumes: Constants come from trog_consts.svh
// Notes:   Types only
package trog_pkg;

	typedef logic [15:0]        trog_word_t;
	typedef logic [7:0]         trog_iaddr_t;
	typedef logic signed [15:0] trog_sample_t;

	// Transfer engine state
	typedef enum logic {
		TROG_IDLE = 1'b0,
		TROG_PEND = 1'b1
	} trog_state_e;

	// Kind of the queued transfer
	typedef enum logic {
		TROG_XFER_READ  = 1'b0,
		TROG_XFER_WRITE = 1'b1
	} trog_xfer_e;

	// Whole state of the bank
	typedef struct packed {
		trog_word_t [15:0] mem;
		trog_word_t        data;
		trog_iaddr_t       addr;
		logic              data_wr;
		trog_state_e       st;
		trog_xfer_e        kind;
		logic              done;
		trog_word_t        rdata;
	} trog_regs_s;

endpackage

//--- hdl/trog_rate_tick.sv
// Purpose: Update-rate strobe for the indirect transfer engine
// Assumes: One clock, asynchronous active-low reset
// Notes:   One-cycle pulse every CYCLES clocks
`timescale 1ns/1ps
`include "trog_consts.svh"

module trog_rate_tick #(
	parameter int CYCLES = `TROG_TICK_CYCLES,
	parameter int CW     = `TROG_TICK_CW
) (
	input  wire logic core_clk_i,
	input  wire logic arst_n_i,
	output logic      tick_o
);
	import trog_pkg::*;

	typedef struct packed {
		logic [CW-1:0] cnt;
		logic          tick;
	} trog_tick_s;

	trog_tick_s s;
	trog_tick_s next_s;

	// Free-running divider
	always_comb begin
		next_s = s;
		next_s.tick = 1'b0;
		if (s.cnt == CW'(CYCLES - 1)) begin
			next_s.cnt = '0;
			next_s.tick = 1'b1;
		end else begin
			next_s.cnt = s.cnt + CW'(1);
		end
	end

	// State register
	always_ff @(posedge core_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			s <= '0;
		end else begin
			s <= next_s;
		end
	end

	assign tick_o = s.tick;

endmodule // trog_rate_tick

//--- hdl/trog_gain_stage.sv
// Purpose: Digital gain multiplier for one audio path
// Assumes: Gain code is signed, unity at 1 << FRAC
// Notes:   One cycle of latency, saturating output
`timescale 1ns/1ps
`include "trog_consts.svh"

module trog_gain_stage #(
	parameter int W    = 16,
	parameter int GW   = 12,
	parameter int FRAC = `TROG_GAIN_FRAC
) (
	input  wire logic                core_clk_i,
	input  wire logic                arst_n_i,
	input  wire logic [GW-1:0]       gain_i,
	input  wire logic signed [W-1:0] sample_i,
	input  wire logic                valid_i,
	output logic signed [W-1:0]      sample_o,
	output logic                     valid_o
);
	import trog_pkg::*;

	typedef struct packed {
		logic signed [W-1:0] smp;
		logic                vld;
	} trog_gain_s;

	localparam logic signed [W+GW-1:0] MAXV = {{(GW+1){1'b0}}, {(W-1){1'b1}}};
	localparam logic signed [W+GW-1:0] MINV = {{(GW+1){1'b1}}, {(W-1){1'b0}}};

	trog_gain_s               s;
	trog_gain_s               next_s;
	logic signed [W+GW-1:0]   prod;
	logic signed [W+GW-1:0]   scaled;

	// Signed product scaled by the unity code
	assign prod   = sample_i * $signed(gain_i);
	assign scaled = prod >>> FRAC;

	// Saturate instead of wrapping
	always_comb begin
		next_s = s;
		next_s.vld = valid_i;
		if (valid_i) begin
			if (scaled > MAXV) begin
				next_s.smp = MAXV[W-1:0];
			end else if (scaled < MINV) begin
				next_s.smp = MINV[W-1:0];
			end else begin
				next_s.smp = scaled[W-1:0];
			end
		end
	end

	// State register
	always_ff @(posedge core_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			s <= '0;
		end else begin
			s <= next_s;
		end
	end

	assign sample_o = s.smp;
	assign valid_o  = s.vld;

	// ****************************************
	// Checks
	// ****************************************
	default clocking cb @(posedge core_clk_i); endclocking
	default disable iff (!arst_n_i);

	AST_GAIN_UNITY: assert property (valid_i && gain_i == GW'(`TROG_GAIN_UNITY) |=>
		valid_o && sample_o == $past(sample_i)) else $error("unity gain altered sample");
	AST_GAIN_MUTE: assert property (valid_i && gain_i == '0 |=> valid_o && sample_o == '0)
		else $error("zero gain did not mute");
	AST_GAIN_SAT: assert property (valid_i && gain_i == GW'(`TROG_GAIN_MAX) && sample_i == MAXV[W-1:0]
		|=> sample_o == MAXV[W-1:0]) else $error("gain overflow wrapped");
	AST_GAIN_HOLD: assert property (!valid_i |=> !valid_o && $stable(sample_o))
		else $error("output changed without a sample");
	COV_GAIN_SAT: cover property (valid_i && scaled > MAXV);

endmodule // trog_gain_stage

//--- hdl/trog_regs.sv
// Purpose: Indirect coefficient bank for tone and ringing oscillators
//          and the two digital audio gain stages
// Assumes: Host strobes are synchronous to core_clk_i
// Notes:   Transfers are serviced on the update-rate tick
`timescale 1ns/1ps
`include "trog_consts.svh"

// How it works
// - Coefficients and gains are signed two's-complement values.
// - Spare bits are stored and read back; host writes them as zero.
// - Locations 0,1,2 hold tone 1 frequency, amplitude, initial phase.
// - Locations 3,4,5 hold tone 2 frequency, amplitude, initial phase.
// - Locations 7,8,9 hold ringing frequency, amplitude, initial phase.
// - Location 6 holds the 6-bit ringing dc offset, 1.5 V per code.
// - Receive gain code multiplies receive samples: 0 mute, 0x400 unity.
// - Transmit gain code multiplies transmit samples: 0 mute, 0x400 unity.
// - Data write then address write queues a store at next update.
// - Address write alone queues a read into the data register.
// - Pending transfers are serviced at a 16 kHz update rate.
// - Status bit reads one while pending; done pulse on completion.
module trog_regs #(
	parameter int TICK_CYCLES = `TROG_TICK_CYCLES,
	parameter int SAMPLE_W    = 16,
	parameter int GAIN_W      = 12
) (
	input  wire logic          core_clk_i,
	input  wire logic          arst_n_i,
	input  wire logic          host_wr_i,
	input  wire logic          host_rd_i,
	input  wire logic [4:0]    host_addr_i,
	input  wire trog_pkg::trog_word_t   host_wdata_i,
	output trog_pkg::trog_word_t        host_rdata_o,
	input  wire trog_pkg::trog_sample_t rx_sample_i,
	input  wire logic          rx_valid_i,
	input  wire trog_pkg::trog_sample_t tx_sample_i,
	input  wire logic          tx_valid_i,
	output trog_pkg::trog_sample_t      rx_sample_o,
	output logic               rx_valid_o,
	output trog_pkg::trog_sample_t      tx_sample_o,
	output logic               tx_valid_o,
	output trog_pkg::trog_word_t        tone1_frequency_coef_o,
	output trog_pkg::trog_word_t        tone1_amplitude_o,
	output trog_pkg::trog_word_t        tone1_initial_phase_o,
	output trog_pkg::trog_word_t        tone2_frequency_coef_o,
	output trog_pkg::trog_word_t        tone2_amplitude_o,
	output trog_pkg::trog_word_t        tone2_initial_phase_o,
	output logic [5:0]         ring_dc_offset_o,
	output trog_pkg::trog_word_t        ring_frequency_coef_o,
	output trog_pkg::trog_word_t        ring_amplitude_o,
	output trog_pkg::trog_word_t        ring_initial_phase_o,
	output logic               indirect_pending_flag_o,
	output logic               indirect_done_interrupt_o
);
	import trog_pkg::*;

	localparam logic [15:0] IMPL_MASK = `TROG_IX_IMPL_MASK;

	trog_regs_s  s;
	trog_regs_s  next_s;
	logic        tick;
	logic [3:0]  idx;
	logic        addr_impl;
	logic        data_wr_req;
	logic        addr_wr_req;
	logic        svc;
	trog_word_t  rd_value;

	// ****************************************
	// Update-rate strobe
	// ****************************************
	trog_rate_tick #(
		.CYCLES (TICK_CYCLES),
		.CW     (`TROG_TICK_CW)
	) u_tick (
		.core_clk_i (core_clk_i),
		.arst_n_i   (arst_n_i),
		.tick_o     (tick)
	);

	// ****************************************
	// Decode
	// ****************************************
	// Host strobes and indirect index
	assign data_wr_req = host_wr_i && (host_addr_i == `TROG_DIR_DATA);
	assign addr_wr_req = host_wr_i && (host_addr_i == `TROG_DIR_ADDR);
	assign idx         = s.addr[3:0];
	assign addr_impl   = (s.addr[7:4] == 4'h0) && IMPL_MASK[idx];
	assign svc         = (s.st == TROG_PEND) && tick;
	assign rd_value    = addr_impl ? s.mem[idx] : `TROG_WORD_RST;

	// ****************************************
	// Transfer engine and direct registers
	// ****************************************
	// Next state of the whole bank
	always_comb begin
		next_s = s;
		next_s.done = 1'b0;
		// Registered read of direct registers
		if (host_rd_i) begin
			case (host_addr_i)
				`TROG_DIR_DATA: begin
					next_s.rdata = s.data;
				end
				`TROG_DIR_ADDR: begin
					next_s.rdata = {8'h00, s.addr};
				end
				`TROG_DIR_STATUS: begin
					next_s.rdata = `TROG_WORD_RST;
					next_s.rdata[`TROG_STAT_PEND_BIT] = (s.st == TROG_PEND);
				end
				default: begin
					next_s.rdata = `TROG_WORD_RST;
				end
			endcase
		end
		// Service the queued transfer on the tick
		unique case (s.st)
			TROG_IDLE: begin
				next_s.st = TROG_IDLE;
			end
			TROG_PEND: begin
				if (tick) begin
					if (s.kind == TROG_XFER_WRITE) begin
						if (addr_impl) begin
							next_s.mem[idx] = s.data;
						end
					end else begin
						next_s.data = rd_value;
					end
					next_s.st = TROG_IDLE;
					next_s.done = 1'b1;
				end
			end
		endcase
		// Host writes come last so they win
		if (data_wr_req) begin
			next_s.data = host_wdata_i;
			next_s.data_wr = 1'b1;
		end
		if (addr_wr_req) begin
			next_s.addr = host_wdata_i[7:0];
			next_s.kind = s.data_wr ? TROG_XFER_WRITE : TROG_XFER_READ;
			next_s.data_wr = 1'b0;
			next_s.st = TROG_PEND;
		end
	end

	// State register
	always_ff @(posedge core_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			s <= '0;
		end else begin
			s <= next_s;
		end
	end

	// ****************************************
	// Outputs
	// ****************************************
	// Coefficients straight from storage, signed words
	assign tone1_frequency_coef_o = s.mem[`TROG_IX_TONE1_FREQ];
	assign tone1_amplitude_o      = s.mem[`TROG_IX_TONE1_AMP];
	assign tone1_initial_phase_o  = s.mem[`TROG_IX_TONE1_PH];
	assign tone2_frequency_coef_o = s.mem[`TROG_IX_TONE2_FREQ];
	assign tone2_amplitude_o      = s.mem[`TROG_IX_TONE2_AMP];
	assign tone2_initial_phase_o  = s.mem[`TROG_IX_TONE2_PH];
	assign ring_dc_offset_o       = s.mem[`TROG_IX_RING_OFS][`TROG_ROF_MSB:0];
	assign ring_frequency_coef_o  = s.mem[`TROG_IX_RING_FREQ];
	assign ring_amplitude_o       = s.mem[`TROG_IX_RING_AMP];
	assign ring_initial_phase_o   = s.mem[`TROG_IX_RING_PH];

	// Status and read data
	assign host_rdata_o              = s.rdata;
	assign indirect_pending_flag_o   = (s.st == TROG_PEND);
	assign indirect_done_interrupt_o = s.done;

	// ****************************************
	// Gain stages
	// ****************************************
	trog_gain_stage #(
		.W    (SAMPLE_W),
		.GW   (GAIN_W),
		.FRAC (`TROG_GAIN_FRAC)
	) u_rx_gain (
		.core_clk_i (core_clk_i),
		.arst_n_i   (arst_n_i),
		.gain_i     (s.mem[`TROG_IX_RX_GAIN][GAIN_W-1:0]),
		.sample_i   (rx_sample_i),
		.valid_i    (rx_valid_i),
		.sample_o   (rx_sample_o),
		.valid_o    (rx_valid_o)
	);

	trog_gain_stage #(
		.W    (SAMPLE_W),
		.GW   (GAIN_W),
		.FRAC (`TROG_GAIN_FRAC)
	) u_tx_gain (
		.core_clk_i (core_clk_i),
		.arst_n_i   (arst_n_i),
		.gain_i     (s.mem[`TROG_IX_TX_GAIN][GAIN_W-1:0]),
		.sample_i   (tx_sample_i),
		.valid_i    (tx_valid_i),
		.sample_o   (tx_sample_o),
		.valid_o    (tx_valid_o)
	);

	// ****************************************
	// Checks
	// ****************************************
	// Age of the pending transfer, for the bound check
	logic [15:0] pend_age;
	always_ff @(posedge core_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			pend_age <= 16'h0000;
		end else if (addr_wr_req || s.st != TROG_PEND) begin
			pend_age <= 16'h0000;
		end else begin
			pend_age <= pend_age + 16'h0001;
		end
	end

	logic svc_wr;
	logic svc_rd;
	assign svc_wr = svc && (s.kind == TROG_XFER_WRITE) && addr_impl;
	assign svc_rd = svc && (s.kind == TROG_XFER_READ) && !data_wr_req;

	// Cycles since the last done pulse, saturating, for the back-to-back cover
	logic [15:0] done_gap;
	always_ff @(posedge core_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			done_gap <= 16'h0000;
		end else if (indirect_done_interrupt_o) begin
			done_gap <= 16'h0001;
		end else if (done_gap != 16'h0000 && done_gap != 16'hFFFF) begin
			done_gap <= done_gap + 16'h0001;
		end
	end

	default clocking cb @(posedge core_clk_i); endclocking
	default disable iff (!arst_n_i);

	AST_PEND_SET: assert property (addr_wr_req |=> indirect_pending_flag_o)
		else $error("address write did not raise pending");
	AST_PEND_BOUND: assert property (pend_age <= 16'(TICK_CYCLES))
		else $error("transfer waited longer than one update period");
	AST_DONE_PULSE: assert property (indirect_done_interrupt_o |-> $past(svc) ##1 !indirect_done_interrupt_o)
		else $error("done not tied to a serviced transfer");
	AST_WR_SVC: assert property (svc_wr && !addr_wr_req |=> !indirect_pending_flag_o
		&& s.mem[$past(idx)] == $past(s.data)) else $error("queued write not stored");
	AST_RD_SVC: assert property (svc_rd |=> s.data == $past(rd_value))
		else $error("queued read not loaded");
	AST_TONE1: assert property (svc_wr && idx == `TROG_IX_TONE1_FREQ |=>
		tone1_frequency_coef_o == $past(s.data)) else $error("tone 1 frequency not updated");
	AST_TONE2: assert property (svc_wr && idx == `TROG_IX_TONE2_PH |=>
		tone2_initial_phase_o == $past(s.data)) else $error("tone 2 phase not updated");
	AST_RING: assert property (svc_wr && idx == `TROG_IX_RING_AMP |=>
		ring_amplitude_o == $past(s.data)) else $error("ringing amplitude not updated");
	AST_ROF: assert property (svc_wr && idx == `TROG_IX_RING_OFS |=>
		ring_dc_offset_o == 6'($past(s.data)) && s.mem[`TROG_IX_RING_OFS] == $past(s.data))
		else $error("ringing offset word not stored whole");
	AST_UNMAPPED: assert property (svc_rd && !addr_impl |=> s.data == `TROG_WORD_RST)
		else $error("unimplemented location did not read zero");
	AST_STATUS_RD: assert property (host_rd_i && host_addr_i == `TROG_DIR_STATUS |=>
		host_rdata_o[`TROG_STAT_PEND_BIT] == $past(indirect_pending_flag_o)) else $error("status bit wrong");

	// Remaining mapped locations reach their outputs; gain words are checked in storage
	AST_TONE1_AMP: assert property (svc_wr && idx == `TROG_IX_TONE1_AMP |=>
		tone1_amplitude_o == $past(s.data)) else $error("tone 1 amplitude not updated");
	AST_TONE1_PH: assert property (svc_wr && idx == `TROG_IX_TONE1_PH |=>
		tone1_initial_phase_o == $past(s.data)) else $error("tone 1 phase not updated");
	AST_TONE2_FREQ: assert property (svc_wr && idx == `TROG_IX_TONE2_FREQ |=>
		tone2_frequency_coef_o == $past(s.data)) else $error("tone 2 frequency not updated");
	AST_TONE2_AMP: assert property (svc_wr && idx == `TROG_IX_TONE2_AMP |=>
		tone2_amplitude_o == $past(s.data)) else $error("tone 2 amplitude not updated");
	AST_RING_FREQ: assert property (svc_wr && idx == `TROG_IX_RING_FREQ |=>
		ring_frequency_coef_o == $past(s.data)) else $error("ringing frequency not updated");
	AST_RING_PH: assert property (svc_wr && idx == `TROG_IX_RING_PH |=>
		ring_initial_phase_o == $past(s.data)) else $error("ringing phase not updated");
	AST_RX_GAIN_WORD: assert property (svc_wr && idx == `TROG_IX_RX_GAIN |=>
		s.mem[`TROG_IX_RX_GAIN] == $past(s.data)) else $error("receive gain not stored");
	AST_TX_GAIN_WORD: assert property (svc_wr && idx == `TROG_IX_TX_GAIN |=>
		s.mem[`TROG_IX_TX_GAIN] == $past(s.data)) else $error("transmit gain not stored");

	// Storage moves only on a serviced write
	AST_MEM_QUIET: assert property (!svc_wr |=> $stable(s.mem))
		else $error("storage changed outside a serviced write");

	// Direct register writes, request kind and reads
	AST_DATA_WR: assert property (data_wr_req |=> s.data == $past(host_wdata_i))
		else $error("data register write lost");
	AST_KIND_WRITE: assert property (addr_wr_req && s.data_wr |=> s.kind == TROG_XFER_WRITE)
		else $error("data then address did not queue a store");
	AST_KIND_READ: assert property (addr_wr_req && !s.data_wr |=> s.kind == TROG_XFER_READ)
		else $error("lone address write did not queue a fetch");
	AST_ADDR_RD: assert property (host_rd_i && host_addr_i == `TROG_DIR_ADDR |=>
		host_rdata_o == {8'h00, $past(s.addr)}) else $error("address register read wrong");
	AST_OTHER_RD: assert property (host_rd_i && host_addr_i != `TROG_DIR_DATA && host_addr_i != `TROG_DIR_ADDR
		&& host_addr_i != `TROG_DIR_STATUS |=> host_rdata_o == `TROG_WORD_RST) else $error("unused address not zero");

	COV_WRITE: cover property (data_wr_req ##[1:4] addr_wr_req ##1 indirect_pending_flag_o);
	COV_WRITE_SVC: cover property (svc_wr && pend_age != 16'h0000);
	COV_READ: cover property (svc_rd && addr_impl);
	COV_DONE: cover property (indirect_done_interrupt_o && done_gap != 16'h0000 && done_gap <= 16'h0514);

endmodule // trog_regs

//--- bench/trog_host_model.sv
// Purpose: Host side of the direct control registers of the coefficient bank
// Assumes: Strobes change at the falling clock edge, one cycle each
// Notes:   Released lines show the inverse of their last value
`timescale 1ns/1ps
`include "trog_consts.svh"

module trog_host_model #(
	parameter int TICK = 40
) (
	input  wire logic                 core_clk_i,
	output logic                      host_wr_o,
	output logic                      host_rd_o,
	output logic [4:0]                host_addr_o,
	output trog_pkg::trog_word_t      host_wdata_o,
	input  wire trog_pkg::trog_word_t host_rdata_i,
	input  wire logic                 pending_i,
	input  wire logic                 done_i
);
	import trog_pkg::*;

	int n_edges;

	// Quiet bus at time zero
	initial begin
		host_wr_o    = 1'b0;
		host_rd_o    = 1'b0;
		host_addr_o  = 5'h00;
		host_wdata_o = 16'h0000;
		n_edges      = 0;
	end

	// One strobed cycle on the register bus
	task automatic cyc(input logic w, input logic r, input logic [4:0] a, input trog_word_t d);
		@(negedge core_clk_i);
		n_edges++;
		host_wr_o    = w;
		host_rd_o    = r;
		host_addr_o  = a;
		host_wdata_o = d;
	endtask

	// Strobes released, lines inverted
	task automatic idle();
		@(negedge core_clk_i);
		n_edges++;
		host_wr_o    = 1'b0;
		host_rd_o    = 1'b0;
		host_addr_o  = ~host_addr_o;
		host_wdata_o = ~host_wdata_o;
	endtask

	// Bounded wait for the done pulse
	task automatic wait_done(output int n);
		while (done_i !== 1'b1 && n_edges < 4 * TICK) begin
			@(negedge core_clk_i);
			n_edges++;
		end
		n = n_edges;
	endtask

	// Direct read, data taken after the read edge
	task automatic reg_rd(input logic [4:0] a, output trog_word_t d);
		cyc(1'b0, 1'b1, a, 16'h0000);
		idle();
		d = host_rdata_i;
	endtask

	// Indirect transfer: data then address for a store, address alone for a fetch
	task automatic ind_xfer(input logic [7:0] loc, input logic wr, input trog_word_t d,
		output logic pend, output int n);
		n_edges = 0;
		if (wr) begin
			cyc(1'b1, 1'b0, `TROG_DIR_DATA, d);
		end
		cyc(1'b1, 1'b0, `TROG_DIR_ADDR, {8'h00, loc});
		idle();
		pend = pending_i;
		wait_done(n);
	endtask
endmodule // trog_host_model

//--- bench/tone_ring_osc_and_gain_regs_bench.sv
// Purpose: Self-checking bench of the coefficient bank and gain stages
// Assumes: Update period shortened through TICK_CYCLES
// Notes:   Random values from a fixed seed
`timescale 1ns/1ps
`include "trog_consts.svh"

module tone_ring_osc_and_gain_regs_bench;
	import trog_pkg::*;

	localparam int TICK = 40;

	logic         core_clk_i = 1'b0;
	logic         arst_n_i   = 1'b0;
	logic         host_wr, host_rd, rx_vin, tx_vin, rx_vout, tx_vout, pend, done, pend_seen;
	logic [4:0]   host_addr;
	logic [5:0]   ring_dc_offset;
	trog_word_t   host_wdata, host_rdata, t1f, t1a, t1p, t2f, t2a, t2p, rgf, rga, rgp, d, r;
	trog_sample_t rx_in, tx_in, rx_out, tx_out, rs, ts;
	trog_word_t   vals [16];
	logic [11:0]  codes [5];
	logic [11:0]  g_rx, g_tx;
	logic [15:0]  impl = `TROG_IX_IMPL_MASK;
	int           bad_count, cmp_count, cycles, n;

	// Clock and cycle ceiling
	always #25 core_clk_i = ~core_clk_i;
	always @(posedge core_clk_i) begin
		cycles++;
		if (cycles == 10000) begin
			bad_count++;
			results();
		end
	end

	trog_regs #(.TICK_CYCLES(TICK)) uut (
		.core_clk_i(core_clk_i), .arst_n_i(arst_n_i), .host_wr_i(host_wr), .host_rd_i(host_rd),
		.host_addr_i(host_addr), .host_wdata_i(host_wdata), .host_rdata_o(host_rdata),
		.rx_sample_i(rx_in), .rx_valid_i(rx_vin), .tx_sample_i(tx_in), .tx_valid_i(tx_vin),
		.rx_sample_o(rx_out), .rx_valid_o(rx_vout), .tx_sample_o(tx_out), .tx_valid_o(tx_vout),
		.tone1_frequency_coef_o(t1f), .tone1_amplitude_o(t1a), .tone1_initial_phase_o(t1p),
		.tone2_frequency_coef_o(t2f), .tone2_amplitude_o(t2a), .tone2_initial_phase_o(t2p),
		.ring_dc_offset_o(ring_dc_offset), .ring_frequency_coef_o(rgf), .ring_amplitude_o(rga),
		.ring_initial_phase_o(rgp), .indirect_pending_flag_o(pend), .indirect_done_interrupt_o(done)
	);

	trog_host_model #(.TICK(TICK)) host (
		.core_clk_i(core_clk_i), .host_wr_o(host_wr), .host_rd_o(host_rd), .host_addr_o(host_addr),
		.host_wdata_o(host_wdata), .host_rdata_i(host_rdata), .pending_i(pend), .done_i(done)
	);

	// Compare and count
	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			bad_count++;
			$display("wrong value at %0t seen %h expected %h", $time, seen, exp);
		end
	endtask

	// Coefficient output of one location
	function automatic trog_word_t obs(input int loc);
		case (loc)
			0: return t1f;
			1: return t1a;
			2: return t1p;
			3: return t2f;
			4: return t2a;
			5: return t2p;
			6: return {10'h000, ring_dc_offset};
			7: return rgf;
			8: return rga;
			default: return rgp;
		endcase
	endfunction

	// Expected gained sample, floor shift and saturation
	function automatic trog_sample_t gain_exp(input trog_sample_t s, input logic [11:0] g);
		logic signed [29:0] p;
		p = s * $signed(g);
		p = p >>> 10;
		if (p > 30'sd32767) return 16'h7FFF;
		if (p < -30'sd32768) return 16'h8000;
		return p[15:0];
	endfunction

	// Counts and verdict
	task automatic results();
		$display("comparisons %0d mismatches %0d", cmp_count, bad_count);
		if (bad_count == 0 && cmp_count > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask

	// ****************************************
	// Main sequence
	// ****************************************
	initial begin
		void'($urandom(2));
		rx_in  = 16'h0000;
		tx_in  = 16'h0000;
		rx_vin = 1'b0;
		tx_vin = 1'b0;
		repeat (12) @(posedge core_clk_i);
		@(negedge core_clk_i);
		arst_n_i = 1'b1;
		// Store every location, requests back to back
		for (int loc = 0; loc < 16; loc++) begin
			d = 16'($urandom);
			if (loc == 6) d = d & 16'h003F;
			if (loc >= 13) d = d & 16'h0FFF;
			vals[loc] = d;
			host.ind_xfer(8'(loc), 1'b1, d, pend_seen, n);
			check(16'(pend_seen), 16'h0001);
			check(16'(pend), 16'h0000);
			check(16'(loc == 0 ? n <= TICK + 1 : n == TICK), 16'h0001);
			if (loc <= 9) check(obs(loc), d);
		end
		$display("test store done");
		// Fetch every location into the data register
		for (int loc = 0; loc < 16; loc++) begin
			host.ind_xfer(8'(loc), 1'b0, 16'h0000, pend_seen, n);
			check(16'(pend_seen), 16'h0001);
			host.reg_rd(`TROG_DIR_DATA, r);
			check(r, impl[loc] ? vals[loc] : 16'h0000);
		end
		$display("test fetch done");
		// Spare bits stored, status while pending, unmapped read
		host.ind_xfer(8'h06, 1'b1, 16'hFFC5, pend_seen, n);
		check(obs(6), 16'h0005);
		host.cyc(1'b1, 1'b0, `TROG_DIR_ADDR, 16'h0006);
		host.idle();
		host.reg_rd(`TROG_DIR_STATUS, r);
		check(r, 16'h0001);
		host.n_edges = 0;
		host.wait_done(n);
		host.reg_rd(`TROG_DIR_DATA, r);
		check(r, 16'hFFC5);
		host.reg_rd(`TROG_DIR_STATUS, r);
		check(r, 16'h0000);
		host.reg_rd(5'h05, r);
		check(r, 16'h0000);
		host.reg_rd(`TROG_DIR_ADDR, r);
		check(r, 16'h0006);
		$display("test status done");
		// Gain codes on both paths, extreme and random samples
		codes = '{12'h000, 12'h400, 12'h7FF, 12'hC00, 12'($urandom)};
		for (int k = 0; k < 5; k++) begin
			g_rx = codes[k];
			g_tx = codes[4 - k];
			host.ind_xfer(8'h0D, 1'b1, {4'h0, g_rx}, pend_seen, n);
			host.ind_xfer(8'h0E, 1'b1, {4'h0, g_tx}, pend_seen, n);
			for (int j = 0; j < 6; j++) begin
				rs = (j == 0) ? 16'h7FFF : (j == 1) ? 16'h8000 : 16'($urandom);
				ts = (j == 0) ? 16'h8000 : (j == 1) ? 16'h7FFF : 16'($urandom);
				@(negedge core_clk_i);
				rx_in  = rs;
				tx_in  = ts;
				rx_vin = 1'b1;
				tx_vin = 1'b1;
				@(negedge core_clk_i);
				rx_vin = 1'b0;
				tx_vin = 1'b0;
				rx_in  = ~rs;
				tx_in  = ~ts;
				check({14'h0000, rx_vout, tx_vout}, 16'h0003);
				check(rx_out, gain_exp(rs, g_rx));
				check(tx_out, gain_exp(ts, g_tx));
			end
		end
		$display("test gain done");
		results();
	end
endmodule // tone_ring_osc_and_gain_regs_bench
